//--- mace_top.v
// Dual-bank multiply-accumulate engine on the processor I/O bus, with two operand memories.
// Function
// - Multiply 16-bit operands to 32 bits, add to the selected 40-bit accumulator.
// - Store each 40-bit sum back into the accumulator that supplied it.
// - One multiply-and-add step completes in each clock cycle.
// - Two 256x16 operand memories each feed the multiplier by a 16-bit port.
// - Each memory has an 8-bit read/write port on the processor bus.
// - Registers decode from address low byte; high byte marks block final transfer.
// - High address byte 01h marks the last transfer of a block instruction.
// - Data bank goes ready on top byte write, or control/low bytes at 01h.
// - Control write with high byte 01h also clears the accumulator.
// - Ready with execution bank empty or done swaps at once; execution starts.
// - Ready data bank waits while a calculation runs, swapping when it ends.
// - A finished calculation swaps in when data bank is empty or ready.
// - Data bank done to empty on top byte read, or lower bytes at 01h.
// - Any write to a mapped register except status takes done data to empty.
// - Each bank keeps accumulator, x/y first, last, wrap values and count.
// - Processor sees only the data bank; execution uses only the other bank.
// - Status bits 1:0 show data bank state, bits 3:2 execution bank state.
// - Data bank codes are 00 empty, 01 ready, 11 done; never 10.
// - Execution bank codes are 00 empty, 10 busy, 11 done; never 01.
// - Writing 80h to status with data empty, execution done forces a swap.
// - Accumulator writes shift left by control bits 2:0, filled with bit 6.
// - Accumulator reads shift right arithmetically by control bits 5:3.
`timescale 1ns/1ns
`include "mace_defines.vh"
module mace_top #(
  parameter ACC_W = `MACE_ACC_W,
  parameter RAM_AW = 8
) (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [15:0] IO_ADDR,
  input wire IO_WR,
  input wire IO_RD,
  input wire [7:0] IO_WDATA,
  output reg [7:0] IO_RDATA,
  input wire XMEM_WR,
  input wire YMEM_WR,
  input wire [RAM_AW:0] MEM_ADDR,
  input wire [7:0] MEM_WDATA,
  output reg [7:0] XMEM_RDATA,
  output reg [7:0] YMEM_RDATA,
  output reg CALC_BUSY
);
  // Bank registers, indexed by physical bank; sel_r names the data bank.
  reg sel_r;
  reg [ACC_W-1:0] acc_r [0:1];
  reg [7:0] xfirst_r [0:1];
  reg [7:0] xlast_r [0:1];
  reg [7:0] xwrap_r [0:1];
  reg [7:0] yfirst_r [0:1];
  reg [7:0] ylast_r [0:1];
  reg [7:0] ywrap_r [0:1];
  reg [7:0] count_r [0:1];
  reg [7:0] ctrl_r;
  reg [1:0] dstate_r;
  reg [1:0] cstate_r;
  reg [7:0] xptr_r;
  reg [7:0] yptr_r;
  reg [8:0] remain_r;
  reg [1:0] dstate_nxt;
  reg [1:0] cstate_nxt;
  reg swap_nxt;
  reg start_nxt;
  wire [7:0] lo = IO_ADDR[7:0];
  // low byte selects, high byte watched.
  // final transfer when the high byte is 01h.
  wire last_xfer = (IO_ADDR[15:8] == `MACE_LAST_XFER);
  wire dsel = sel_r;
  wire csel = ~sel_r;
  wire is_acc_lo = (lo <= `MACE_OFF_ACC3);
  wire is_acc4 = (lo == `MACE_OFF_ACC4);
  wire is_ctrl = (lo == `MACE_OFF_CTRL);
  wire is_stat = (lo == `MACE_OFF_STATUS);
  wire mapped = (lo <= `MACE_OFF_STATUS);
  wire wr_acc = IO_WR && (is_acc_lo || is_acc4);
  wire [2:0] in_sh = ctrl_r[`MACE_CTL_INSH_LSB +: 3];
  wire [2:0] out_sh = ctrl_r[`MACE_CTL_OUTSH_LSB +: 3];
  wire noise = ctrl_r[`MACE_CTL_NOISE];
  // shifted write image of one byte and its field mask.
  wire [2:0] byte_idx = lo[2:0];
  wire [5:0] bit_pos = {byte_idx, 3'h0} + {3'h0, in_sh};
  wire [ACC_W+7:0] wr_img = ({{ACC_W{1'b0}}, IO_WDATA} << bit_pos) | (((byte_idx == 3'h0) && noise) ?
    (({{ACC_W{1'b0}}, 8'h01} << in_sh) - {{ACC_W{1'b0}}, 8'h01}) : {(ACC_W+8){1'b0}});
  wire [ACC_W+7:0] wr_msk = ({{ACC_W{1'b0}}, 8'hff} << bit_pos) | ((byte_idx == 3'h0) ?
    (({{ACC_W{1'b0}}, 8'h01} << in_sh) - {{ACC_W{1'b0}}, 8'h01}) : {(ACC_W+8){1'b0}});
  wire [ACC_W-1:0] acc_wr_val = (acc_r[dsel] & ~wr_msk[ACC_W-1:0]) | wr_img[ACC_W-1:0];
  wire signed [ACC_W-1:0] acc_rd_sh = $signed(acc_r[dsel]) >>> out_sh;
  wire [ACC_W-1:0] acc_rd_val = acc_rd_sh;
  // Operand memories and the multiply-add unit.
  wire [15:0] xop;
  wire [15:0] yop;
  wire [7:0] xrd;
  wire [7:0] yrd;
  wire [ACC_W-1:0] acc_sum;
  mace_oper_ram #(.DEPTH(`MACE_RAM_DEPTH), .AW(RAM_AW)) u_xram (
    .clk(SYS_CLK),
    .cpu_we(XMEM_WR),
    .cpu_addr(MEM_ADDR),
    .cpu_wdata(MEM_WDATA),
    .cpu_rdata(xrd),
    .mac_addr(xptr_r),
    .mac_rdata(xop)
  );
  mace_oper_ram #(.DEPTH(`MACE_RAM_DEPTH), .AW(RAM_AW)) u_yram (
    .clk(SYS_CLK),
    .cpu_we(YMEM_WR),
    .cpu_addr(MEM_ADDR),
    .cpu_wdata(MEM_WDATA),
    .cpu_rdata(yrd),
    .mac_addr(yptr_r),
    .mac_rdata(yop)
  );
  mace_mac_unit #(.AW(ACC_W)) u_mac (
    .op_x(xop),
    .op_y(yop),
    .acc_in(acc_r[csel]),
    .acc_out(acc_sum)
  );
  wire busy = (cstate_r == `MACE_CS_BUSY);
  wire finish = busy && (remain_r == 9'h001);
  // Bank state machine: next states, swap and start decisions.
  always @* begin
    dstate_nxt = dstate_r;
    cstate_nxt = cstate_r;
    swap_nxt = 1'b0;
    start_nxt = 1'b0;
    // non-status write to a mapped register ends a done bank.
    if (IO_WR && mapped && !is_stat && dstate_r == `MACE_DS_DONE) begin
      dstate_nxt = `MACE_DS_EMPTY;
    end
    // reads that release a done bank.
    if (IO_RD && dstate_r == `MACE_DS_DONE && (is_acc4 || (is_acc_lo && last_xfer))) begin
      dstate_nxt = `MACE_DS_EMPTY;
    end
    // writes that make the data bank ready.
    if (IO_WR && (is_acc4 || ((is_acc_lo || is_ctrl) && last_xfer))) begin
      dstate_nxt = `MACE_DS_READY;
    end
    // forced swap of a finished result.
    if (IO_WR && is_stat && IO_WDATA == `MACE_FORCE_SWAP && dstate_r == `MACE_DS_EMPTY &&
        cstate_r == `MACE_CS_DONE) begin
      swap_nxt = 1'b1;
      dstate_nxt = `MACE_DS_DONE;
      cstate_nxt = `MACE_CS_EMPTY;
    end else if (finish) begin
      // a waiting ready bank starts after the finish.
      // finished result swaps into the data side.
      if (dstate_nxt == `MACE_DS_READY) begin
        swap_nxt = 1'b1;
        start_nxt = 1'b1;
        dstate_nxt = `MACE_DS_DONE;
        cstate_nxt = `MACE_CS_BUSY;
      end else if (dstate_nxt == `MACE_DS_EMPTY) begin
        swap_nxt = 1'b1;
        dstate_nxt = `MACE_DS_DONE;
        cstate_nxt = `MACE_CS_EMPTY;
      end else begin
        cstate_nxt = `MACE_CS_DONE;
      end
    end else if (dstate_nxt == `MACE_DS_READY && !busy) begin
      swap_nxt = 1'b1;
      start_nxt = 1'b1;
      dstate_nxt = (cstate_r == `MACE_CS_DONE) ? `MACE_DS_DONE : `MACE_DS_EMPTY;
      cstate_nxt = `MACE_CS_BUSY;
    end
  end
  // data bank never takes code 10.
  // execution bank never takes code 01.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sel_r <= 1'b0;
      dstate_r <= `MACE_DS_EMPTY;
      cstate_r <= `MACE_CS_EMPTY;
      ctrl_r <= 8'h00;
    end else begin
      dstate_r <= dstate_nxt;
      cstate_r <= cstate_nxt;
      if (swap_nxt) begin
        sel_r <= ~sel_r;
      end
      if (IO_WR && is_ctrl) begin
        ctrl_r <= IO_WDATA;
      end
    end
  end
  // per-bank parameter registers, written only through the data bank.
  // processor writes touch only the data bank.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      xfirst_r[0] <= 8'h00;
      xfirst_r[1] <= 8'h00;
      xlast_r[0] <= 8'h00;
      xlast_r[1] <= 8'h00;
      xwrap_r[0] <= 8'h00;
      xwrap_r[1] <= 8'h00;
      yfirst_r[0] <= 8'h00;
      yfirst_r[1] <= 8'h00;
      ylast_r[0] <= 8'h00;
      ylast_r[1] <= 8'h00;
      ywrap_r[0] <= 8'h00;
      ywrap_r[1] <= 8'h00;
      count_r[0] <= 8'h00;
      count_r[1] <= 8'h00;
    end else if (IO_WR) begin
      case (lo)
        `MACE_OFF_XFIRST: xfirst_r[dsel] <= IO_WDATA;
        `MACE_OFF_XLAST: xlast_r[dsel] <= IO_WDATA;
        `MACE_OFF_XWRAP: xwrap_r[dsel] <= IO_WDATA;
        `MACE_OFF_YFIRST: yfirst_r[dsel] <= IO_WDATA;
        `MACE_OFF_YLAST: ylast_r[dsel] <= IO_WDATA;
        `MACE_OFF_YWRAP: ywrap_r[dsel] <= IO_WDATA;
        `MACE_OFF_COUNT: count_r[dsel] <= IO_WDATA;
        default: begin
        end
      endcase
    end
  end
  // Accumulators: processor writes land on the data bank, execution on the other.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      acc_r[0] <= {ACC_W{1'b0}};
      acc_r[1] <= {ACC_W{1'b0}};
    end else begin
      // final control write clears the accumulator.
      if (IO_WR && is_ctrl && last_xfer) begin
        acc_r[dsel] <= {ACC_W{1'b0}};
      end else if (wr_acc) begin
        acc_r[dsel] <= acc_wr_val;
      end
      // sum returns to its own accumulator.
      if (busy) begin
        acc_r[csel] <= acc_sum;
      end
    end
  end
  // address sequencing over the execution bank, count zero means 256 products.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      xptr_r <= 8'h00;
      yptr_r <= 8'h00;
      remain_r <= 9'h000;
    end else if (start_nxt) begin
      xptr_r <= swap_nxt ? xfirst_r[dsel] : xfirst_r[csel];
      yptr_r <= swap_nxt ? yfirst_r[dsel] : yfirst_r[csel];
      remain_r <= (count_r[dsel] == 8'h00) ? 9'h100 : {1'b0, count_r[dsel]};
    end else if (busy) begin
      xptr_r <= (xptr_r == xlast_r[csel]) ? xwrap_r[csel] : xptr_r + 8'h01;
      yptr_r <= (yptr_r == ylast_r[csel]) ? ywrap_r[csel] : yptr_r + 8'h01;
      remain_r <= remain_r - 9'h001;
    end
  end
  // Registered read data; status layout.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      IO_RDATA <= 8'h00;
      XMEM_RDATA <= 8'h00;
      YMEM_RDATA <= 8'h00;
      CALC_BUSY <= 1'b0;
    end else begin
      XMEM_RDATA <= xrd;
      YMEM_RDATA <= yrd;
      CALC_BUSY <= (cstate_nxt == `MACE_CS_BUSY);
      case (lo)
        `MACE_OFF_ACC0: IO_RDATA <= acc_rd_val[7:0];
        `MACE_OFF_ACC1: IO_RDATA <= acc_rd_val[15:8];
        `MACE_OFF_ACC2: IO_RDATA <= acc_rd_val[23:16];
        `MACE_OFF_ACC3: IO_RDATA <= acc_rd_val[31:24];
        `MACE_OFF_ACC4: IO_RDATA <= acc_rd_val[39:32];
        `MACE_OFF_XFIRST: IO_RDATA <= xfirst_r[dsel];
        `MACE_OFF_XLAST: IO_RDATA <= xlast_r[dsel];
        `MACE_OFF_XWRAP: IO_RDATA <= xwrap_r[dsel];
        `MACE_OFF_YFIRST: IO_RDATA <= yfirst_r[dsel];
        `MACE_OFF_YLAST: IO_RDATA <= ylast_r[dsel];
        `MACE_OFF_YWRAP: IO_RDATA <= ywrap_r[dsel];
        `MACE_OFF_COUNT: IO_RDATA <= count_r[dsel];
        `MACE_OFF_CTRL: IO_RDATA <= ctrl_r;
        `MACE_OFF_STATUS: IO_RDATA <= {4'h0, cstate_r, dstate_r};
        default: IO_RDATA <= 8'h00;
      endcase
    end
  end
endmodule // mace_top

//--- mace_defines.vh
// Register offsets, field positions, state codes and sizes of the multiply-accumulate engine.
`ifndef MACE_DEFINES_VH
`define MACE_DEFINES_VH
`define MACE_OFF_ACC0 8'h00
`define MACE_OFF_ACC1 8'h01
`define MACE_OFF_ACC2 8'h02
`define MACE_OFF_ACC3 8'h03
`define MACE_OFF_ACC4 8'h04
`define MACE_OFF_XFIRST 8'h05
`define MACE_OFF_XLAST 8'h06
`define MACE_OFF_XWRAP 8'h07
`define MACE_OFF_YFIRST 8'h08
`define MACE_OFF_YLAST 8'h09
`define MACE_OFF_YWRAP 8'h0a
`define MACE_OFF_COUNT 8'h0b
`define MACE_OFF_CTRL 8'h0c
`define MACE_OFF_STATUS 8'h0d
`define MACE_LAST_XFER 8'h01
`define MACE_FORCE_SWAP 8'h80
`define MACE_DS_EMPTY 2'h0
`define MACE_DS_READY 2'h1
`define MACE_DS_DONE 2'h3
`define MACE_CS_EMPTY 2'h0
`define MACE_CS_BUSY 2'h2
`define MACE_CS_DONE 2'h3
`define MACE_CTL_INSH_LSB 0
`define MACE_CTL_OUTSH_LSB 3
`define MACE_CTL_NOISE 6
`define MACE_ACC_W 40
`define MACE_OPD_W 16
`define MACE_RAM_DEPTH 256
`endif

//--- mace_oper_ram.v
// Operand memory: 16-bit read port for the multiplier and 8-bit read/write byte port for the processor.
`timescale 1ns/1ns
module mace_oper_ram #(
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire clk,
  input wire cpu_we,
  input wire [AW:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  output wire [7:0] cpu_rdata,
  input wire [AW-1:0] mac_addr,
  output wire [15:0] mac_rdata
);
  reg [7:0] mem_lo [0:DEPTH-1];
  reg [7:0] mem_hi [0:DEPTH-1];
  always @(posedge clk) begin
    if (cpu_we && !cpu_addr[0]) begin
      mem_lo[cpu_addr[AW:1]] <= cpu_wdata;
    end
    if (cpu_we && cpu_addr[0]) begin
      mem_hi[cpu_addr[AW:1]] <= cpu_wdata;
    end
  end
  // Byte port reads; even byte is the low half of a word.
  assign cpu_rdata = cpu_addr[0] ? mem_hi[cpu_addr[AW:1]] : mem_lo[cpu_addr[AW:1]];
  assign mac_rdata = {mem_hi[mac_addr], mem_lo[mac_addr]};
endmodule // mace_oper_ram

//--- mace_mac_unit.v
// Single-cycle 16x16 multiplier with 40-bit accumulate.
`timescale 1ns/1ns
module mace_mac_unit #(
  parameter AW = 40
) (
  input wire [15:0] op_x,
  input wire [15:0] op_y,
  input wire [AW-1:0] acc_in,
  output wire [AW-1:0] acc_out
);
  wire signed [31:0] prod;
  // signed product added to the accumulator.
  assign prod = $signed(op_x) * $signed(op_y);
  assign acc_out = acc_in + {{(AW-32){prod[31]}}, prod};
endmodule // mace_mac_unit

//--- mace_checker.sv
// Port-level assertions for the multiply-accumulate engine.
`timescale 1ns/1ns
module mace_checker #(
  parameter RAM_AW = 8
) (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [15:0] IO_ADDR,
  input wire IO_WR,
  input wire IO_RD,
  input wire [7:0] IO_WDATA,
  input wire [7:0] IO_RDATA,
  input wire XMEM_WR,
  input wire YMEM_WR,
  input wire [RAM_AW:0] MEM_ADDR,
  input wire [7:0] MEM_WDATA,
  input wire [7:0] XMEM_RDATA,
  input wire [7:0] YMEM_RDATA,
  input wire CALC_BUSY
);
  // A write that makes the data bank ready.
  wire trig = IO_WR && (IO_ADDR[7:0] == 8'h04 || (IO_ADDR[15:8] == 8'h01 &&
    (IO_ADDR[7:0] < 8'h04 || IO_ADDR[7:0] == 8'h0c)));
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Bank states, start conditions and the read paths.
  property p_rst_quiet;
    $rose(RST_N) |-> !CALC_BUSY && IO_RDATA == 8'h00;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
  property p_codes;
    IO_ADDR[7:0] == 8'h0d |=> IO_RDATA[1:0] != 2'b10 && IO_RDATA[3:2] != 2'b01 && IO_RDATA[7:4] == 4'h0;
  endproperty
  a_codes: assert property (p_codes) else $error("illegal status code");
  property p_busy_stat;
    IO_ADDR[7:0] == 8'h0d |=> (IO_RDATA[3:2] == 2'b10) == $past(CALC_BUSY);
  endproperty
  a_busy_stat: assert property (p_busy_stat) else $error("status and busy disagree");
  property p_start;
    trig && !CALC_BUSY |-> ##[1:2] CALC_BUSY;
  endproperty
  a_start: assert property (p_start) else $error("ready write did not start");
  property p_nostart;
    IO_WR && IO_ADDR[15:8] == 8'h00 && IO_ADDR[7:0] != 8'h04 && !CALC_BUSY && !$past(trig) |=> !CALC_BUSY;
  endproperty
  a_nostart: assert property (p_nostart) else $error("plain write started work");
  property p_unmapped;
    IO_ADDR[7:0] > 8'h0d |=> IO_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_xmem;
    XMEM_WR ##1 (!XMEM_WR && $stable(MEM_ADDR)) |=> XMEM_RDATA == $past(MEM_WDATA, 2);
  endproperty
  a_xmem: assert property (p_xmem) else $error("x byte readback wrong");
  property p_ymem;
    YMEM_WR ##1 (!YMEM_WR && $stable(MEM_ADDR)) |=> YMEM_RDATA == $past(MEM_WDATA, 2);
  endproperty
  a_ymem: assert property (p_ymem) else $error("y byte readback wrong");
  property p_xhold;
    !XMEM_WR ##1 (!XMEM_WR && $stable(MEM_ADDR)) |=> $stable(XMEM_RDATA);
  endproperty
  a_xhold: assert property (p_xhold) else $error("x memory changed unwritten");
  // Main scenarios.
  c_start: cover property (trig && !CALC_BUSY);
  c_queue: cover property (trig && CALC_BUSY);
  c_end: cover property ($fell(CALC_BUSY));
endmodule // mace_checker

//--- mace_host.sv
// Processor model driving the engine's I/O bus and operand memory byte port.
`timescale 1ns/1ns
module mace_host (
  input wire clk,
  output reg [15:0] io_addr,
  output reg io_wr,
  output reg io_rd,
  output reg [7:0] io_wdata,
  input wire [7:0] io_rdata,
  output reg xmem_wr,
  output reg ymem_wr,
  output reg [8:0] mem_addr,
  output reg [7:0] mem_wdata
);
  // Idle bus points at an unmapped register.
  initial begin
    io_addr = 16'h00ff;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    xmem_wr = 1'b0;
    ymem_wr = 1'b0;
    mem_addr = 9'h000;
    mem_wdata = 8'h00;
  end
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
      io_addr <= 16'h00ff;
      io_wdata <= ~d;
    end
  endtask
  // Read data is registered, so it is taken one cycle after the strobe.
  task rd(input [15:0] a, output [7:0] d);
    begin
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      io_addr <= 16'h00ff;
      #1 d = io_rdata;
    end
  endtask
  task blk(input [7:0] a, input [7:0] n, input [63:0] d);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
        wr({n - i[7:0], a + i[7:0]}, d[8*i +: 8]);
    end
  endtask
  // One byte into the x or y memory; the address is held afterwards.
  task mw(input s, input [8:0] a, input [7:0] d);
    begin
      @(posedge clk);
      mem_addr <= a;
      mem_wdata <= d;
      xmem_wr <= !s;
      ymem_wr <= s;
      @(posedge clk);
      xmem_wr <= 1'b0;
      ymem_wr <= 1'b0;
      mem_wdata <= ~d;
    end
  endtask
endmodule // mace_host

//--- mace_tb_top.sv
// Self-checking bench for the dual-bank multiply-accumulate engine.
`timescale 1ns/1ns
module mace_tb_top;
  reg clk;
  reg rst_n;
  wire [15:0] ia;
  wire iw;
  wire ir;
  wire [7:0] iwd;
  wire [7:0] ird;
  wire xw;
  wire yw;
  wire [8:0] ma;
  wire [7:0] mwd;
  wire [7:0] xrd;
  wire [7:0] yrd;
  wire busy;
  reg [7:0] v;
  integer i;
  integer num_errors;
  integer num_checks;
  mace_top uut (.SYS_CLK(clk), .RST_N(rst_n), .IO_ADDR(ia), .IO_WR(iw), .IO_RD(ir), .IO_WDATA(iwd),
    .IO_RDATA(ird), .XMEM_WR(xw), .YMEM_WR(yw), .MEM_ADDR(ma), .MEM_WDATA(mwd), .XMEM_RDATA(xrd),
    .YMEM_RDATA(yrd), .CALC_BUSY(busy));
  mace_host h (.clk(clk), .io_addr(ia), .io_wr(iw), .io_rd(ir), .io_wdata(iwd), .io_rdata(ird),
    .xmem_wr(xw), .ymem_wr(yw), .mem_addr(ma), .mem_wdata(mwd));
  // Compare, count and report.
  task chk(input [63:0] n, input [7:0] e, input [7:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task st(input [7:0] e);
    begin
      h.rd(16'h000d, v);
      chk("status", e, v);
    end
  endtask
  // Polls status with a bounded number of reads.
  task wst(input [7:0] e);
    integer k;
    begin
      v = ~e;
      for (k = 0; k < 400 && v !== e; k = k + 1)
        h.rd(16'h000d, v);
      chk("status", e, v);
    end
  endtask
  task t_reset;
    begin
      st(8'h00);
      h.rd(16'h0020, v);
      chk("unmapped", 8'h00, v);
      $display("reset test done");
    end
  endtask
  task t_shift;
    begin
      h.wr(16'h000c, 8'h41);
      h.wr(16'h0000, 8'h80);
      h.rd(16'h0000, v);
      chk("acc in", 8'h01, v);
      h.wr(16'h000c, 8'h08);
      h.rd(16'h0000, v);
      chk("acc out", 8'h80, v);
      st(8'h00);
      $display("shift test done");
    end
  endtask
  task t_mem;
    begin
      for (i = 3; i >= 0; i = i - 1) begin
        h.mw(1'b0, i[8:0], 32'h00020003 >> (8 * i));
        h.mw(1'b1, i[8:0], 32'h00070005 >> (8 * i));
      end
      repeat (2) @(posedge clk);
      #1;
      chk("xmem", 8'h03, xrd);
      chk("ymem", 8'h05, yrd);
      $display("memory test done");
    end
  endtask
  task t_calc;
    begin
      h.blk(8'h05, 8'h07, 64'h000200ff0000ff00);
      st(8'h00);
      h.wr(16'h010c, 8'h00);
      wst(8'h03);
      for (i = 0; i < 5; i = i + 1) begin
        h.rd({8'h00, i[7:0]}, v);
        chk("acc", 40'd29 >> (8 * i), v);
      end
      st(8'h00);
      $display("calc test done");
    end
  endtask
  task t_queue;
    begin
      h.wr(16'h000b, 8'h00);
      h.wr(16'h010c, 8'h00);
      @(posedge clk);
      #1;
      chk("busy", 8'h01, {7'h00, busy});
      h.blk(8'h05, 8'h07, 64'h000200ff0000ff00);
      h.wr(16'h010c, 8'h00);
      st(8'h09);
      wst(8'h0f);
      h.rd(16'h0004, v);
      st(8'h0c);
      h.wr(16'h000d, 8'h80);
      st(8'h03);
      h.rd(16'h0000, v);
      chk("acc b", 8'h1d, v);
      h.wr(16'h0005, 8'h00);
      st(8'h00);
      h.wr(16'h0004, 8'h80);
      wst(8'h03);
      h.wr(16'h000c, 8'h08);
      h.rd(16'h0004, v);
      chk("acc sign", 8'hc0, v);
      h.rd(16'h0000, v);
      chk("acc lsb", 8'h1d, v);
      $display("queue test done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Reset, then the scenarios in order.
  initial begin
    num_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_shift;
    t_mem;
    t_calc;
    t_queue;
    final_report;
  end
  // Watchdog far beyond the few hundred cycles the scenarios need.
  initial begin
    #200000;
    num_errors = num_errors + 1;
    final_report;
  end
endmodule // mace_tb_top
bind mace_top mace_checker #(.RAM_AW(RAM_AW)) chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .IO_ADDR(IO_ADDR),
  .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .XMEM_WR(XMEM_WR),
  .YMEM_WR(YMEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .XMEM_RDATA(XMEM_RDATA),
  .YMEM_RDATA(YMEM_RDATA), .CALC_BUSY(CALC_BUSY));
